//--- src/rial_pkg.sv
package rial_pkg;

	// ----------------------------------------------------------------
	// Register offsets on the special function register map.
	// ----------------------------------------------------------------
	localparam logic [7:0] RIAL_OFS_ADDR = 8'hAC;
	localparam logic [7:0] RIAL_OFS_DATA = 8'hAD;
	localparam logic [7:0] RIAL_OFS_KEY = 8'hAE;

	// ----------------------------------------------------------------
	// Reset values, key values and status codes.
	// ----------------------------------------------------------------
	localparam logic [7:0] RIAL_RST_ADDR = 8'h00;
	localparam logic [7:0] RIAL_RST_DATA = 8'h00;
	localparam logic [7:0] RIAL_KEY_FIRST = 8'hA5;
	localparam logic [7:0] RIAL_KEY_SECOND = 8'hF1;
	localparam logic [7:0] RIAL_CODE_LOCKED = 8'h00;
	localparam logic [7:0] RIAL_CODE_WAIT2 = 8'h01;
	localparam logic [7:0] RIAL_CODE_OPEN = 8'h02;
	localparam logic [7:0] RIAL_CODE_DISABLED = 8'h03;

	// ----------------------------------------------------------------
	// Field positions in the address register.
	// ----------------------------------------------------------------
	localparam int RIAL_BIT_BUSY = 7;
	localparam int RIAL_BIT_AUTO_READ = 6;
	localparam int RIAL_BIT_UNUSED = 5;
	localparam int RIAL_BIT_SHORT = 4;

	// ----------------------------------------------------------------
	// Internal index ranges that auto-increment.
	// ----------------------------------------------------------------
	localparam logic [3:0] RIAL_SNAP_FIRST = 4'h0;
	localparam logic [3:0] RIAL_SNAP_LAST = 4'h3;
	localparam logic [3:0] RIAL_MATCH_FIRST = 4'h8;
	localparam logic [3:0] RIAL_MATCH_LAST = 4'hB;

	// ----------------------------------------------------------------
	// Access timing in system clock cycles.
	// ----------------------------------------------------------------
	localparam logic [2:0] RIAL_CYC_NORMAL = 3'h7;
	localparam logic [2:0] RIAL_CYC_SHORT = 3'h6;

	// ----------------------------------------------------------------
	// Carriers.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rial_sfr_req_t;

	typedef struct packed {
		logic wr_stb;
		logic rd_stb;
		logic [3:0] index;
		logic [7:0] wdata;
	} rial_core_req_t;

	typedef enum logic [1:0] {
		RIAL_LOCKED,
		RIAL_WAIT2,
		RIAL_OPEN,
		RIAL_DISABLED
	} rial_lock_t;

endpackage : rial_pkg

//--- src/rial_strobe_timer.sv
module rial_strobe_timer (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic short_mode,
	output logic busy,
	output logic done
);
	import rial_pkg::*;

	logic [2:0] count;

	// ----------------------------------------------------------------
	// Access length counter.
	// ----------------------------------------------------------------
	// A start while busy is dropped; the caller only starts when idle.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			count <= 3'h0;
		end else if (start && count == 3'h0) begin
			count <= short_mode ? RIAL_CYC_SHORT : RIAL_CYC_NORMAL; // [RQ18]
		end else if (count != 3'h0) begin
			count <= count - 3'h1;
		end
	end

	// Busy covers the whole access; done marks its last cycle.
	assign busy = (count != 3'h0); // [RQ20]
	assign done = (count == 3'h1);

	AST_NORMAL_LEN: assert property (@(posedge core_clk) disable iff (rst) // [RQ18]
		start && !busy && !short_mode |=> busy [*7] ##1 !busy)
		else $error("normal access not seven cycles");
	AST_SHORT_LEN: assert property (@(posedge core_clk) disable iff (rst) // [RQ18]
		start && !busy && short_mode |=> busy [*6] ##1 !busy)
		else $error("short access not six cycles");

endmodule // rial_strobe_timer

//--- src/rial_gateway.sv
// Operation
// RQ1 - Status reads 0x00 locked, 0x01 after A5.
// RQ2 - Both keys in order read as 0x02.
// RQ3 - Code 0x03 means disabled until reset.
// RQ4 - Writing A5 then F1 unlocks the gateway.
// RQ5 - Wrong second key disables the gateway.
// RQ6 - Any key write while unlocked relocks.
// RQ7 - Key writes ignored while disabled.
// RQ8 - Address bit 7 shows busy, starts reads.
// RQ9 - Address bit 6 enables auto-read.
// RQ10 - Address bit 5 reads zero, ignores writes.
// RQ11 - Address bit 4 selects short strobe timing.
// RQ12 - Low four address bits select internal register.
// RQ13 - Index increments after snapshot or match access.
// RQ14 - Data register holds last transferred byte.
// RQ15 - Software avoids read-modify-write on data register.
// RQ16 - Bad keys or locked access disable gateway.
// RQ17 - Data register write starts indirect write.
// RQ18 - Access takes seven cycles, six when short.
// RQ19 - Auto-read: data read starts next read.
// RQ20 - Busy holds until transfer completes, data loaded.
module rial_gateway (
	input wire logic core_clk,
	input wire logic rst,
	input wire rial_pkg::rial_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	output rial_pkg::rial_core_req_t core_req,
	input wire logic [7:0] core_rdata
);
	import rial_pkg::*;

	rial_lock_t lock_state;
	logic auto_read_enable;
	logic short_strobe;
	logic [3:0] index;
	logic [7:0] data_window;
	logic access_is_read;
	logic busy;
	logic done;
	logic start;
	logic [7:0] lock_state_code;

	// ----------------------------------------------------------------
	// Decoding.
	// ----------------------------------------------------------------
	// Indices 0..3 and 8..11 carry multi-byte values and auto-increment.
	function automatic logic rial_is_multibyte(input logic [3:0] idx);
		return (idx >= RIAL_SNAP_FIRST && idx <= RIAL_SNAP_LAST) ||
			(idx >= RIAL_MATCH_FIRST && idx <= RIAL_MATCH_LAST);
	endfunction

	function automatic logic rial_hit(input rial_sfr_req_t req, input logic [7:0] ofs);
		return req.addr == ofs;
	endfunction

	logic key_wr, adr_wr, dat_wr, dat_rd, open, read_go, write_go, illegal_access;
	logic timer_short;
	assign key_wr = sfr_req.wr && rial_hit(sfr_req, RIAL_OFS_KEY);
	assign adr_wr = sfr_req.wr && rial_hit(sfr_req, RIAL_OFS_ADDR);
	assign dat_wr = sfr_req.wr && rial_hit(sfr_req, RIAL_OFS_DATA);
	assign dat_rd = sfr_req.rd && rial_hit(sfr_req, RIAL_OFS_DATA);
	assign open = (lock_state == RIAL_OPEN);

	// Requests made while busy are dropped, so software must poll busy.
	assign read_go = open && !busy &&
		((adr_wr && sfr_req.wdata[RIAL_BIT_BUSY]) || // [RQ8]
		(dat_rd && auto_read_enable)); // [RQ19]
	assign write_go = open && !busy && dat_wr; // [RQ17]
	assign start = read_go || write_go;

	// An address write that also sets busy runs with the timing it writes, not the old one.
	assign timer_short = (open && adr_wr && !busy) ? sfr_req.wdata[RIAL_BIT_SHORT] :
		short_strobe; // [RQ11]

	// An indirect attempt while still locked is treated as an attack.
	assign illegal_access = (lock_state == RIAL_LOCKED || lock_state == RIAL_WAIT2) &&
		(dat_wr || dat_rd || (adr_wr && sfr_req.wdata[RIAL_BIT_BUSY])); // [RQ16]

	// ----------------------------------------------------------------
	// Lock and key sequencer.
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lock_state <= RIAL_LOCKED;
		end else begin
			unique case (lock_state)
				RIAL_LOCKED: begin
					if (illegal_access) begin
						lock_state <= RIAL_DISABLED; // [RQ16]
					end else if (key_wr) begin
						lock_state <= (sfr_req.wdata == RIAL_KEY_FIRST) ?
							RIAL_WAIT2 : RIAL_DISABLED; // [RQ4] [RQ16]
					end
				end
				RIAL_WAIT2: begin
					if (illegal_access) begin
						lock_state <= RIAL_DISABLED; // [RQ16]
					end else if (key_wr) begin
						lock_state <= (sfr_req.wdata == RIAL_KEY_SECOND) ?
							RIAL_OPEN : RIAL_DISABLED; // [RQ4] [RQ5]
					end
				end
				RIAL_OPEN: begin
					if (key_wr) begin
						lock_state <= RIAL_LOCKED; // [RQ6]
					end
				end
				RIAL_DISABLED: begin
					lock_state <= RIAL_DISABLED; // [RQ3] [RQ7]
				end
			endcase
		end
	end

	// Status code as software sees it.
	always_comb begin
		unique case (lock_state)
			RIAL_LOCKED: lock_state_code = RIAL_CODE_LOCKED; // [RQ1]
			RIAL_WAIT2: lock_state_code = RIAL_CODE_WAIT2; // [RQ1]
			RIAL_OPEN: lock_state_code = RIAL_CODE_OPEN; // [RQ2]
			RIAL_DISABLED: lock_state_code = RIAL_CODE_DISABLED; // [RQ3]
		endcase
	end

	// ----------------------------------------------------------------
	// Address register.
	// ----------------------------------------------------------------
	// Writes are accepted only while open; a completed multi-byte access
	// steps the index so four bytes can be moved without rewriting it.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			auto_read_enable <= RIAL_RST_ADDR[RIAL_BIT_AUTO_READ];
			short_strobe <= RIAL_RST_ADDR[RIAL_BIT_SHORT];
			index <= RIAL_RST_ADDR[3:0];
		end else if (open && adr_wr && !busy) begin
			auto_read_enable <= sfr_req.wdata[RIAL_BIT_AUTO_READ]; // [RQ9]
			short_strobe <= sfr_req.wdata[RIAL_BIT_SHORT]; // [RQ11]
			index <= sfr_req.wdata[3:0]; // [RQ12]
		end else if (done && rial_is_multibyte(index)) begin
			index <= index + 4'h1; // [RQ13]
		end
	end

	// ----------------------------------------------------------------
	// Data window and access direction.
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			data_window <= RIAL_RST_DATA;
			access_is_read <= 1'b0;
		end else begin
			if (start) begin
				access_is_read <= read_go;
			end
			if (write_go) begin
				data_window <= sfr_req.wdata; // [RQ14] [RQ17]
			end else if (done && access_is_read) begin
				data_window <= core_rdata; // [RQ14] [RQ20]
			end
		end
	end

	rial_strobe_timer u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.start(start),
		.short_mode(timer_short),
		.busy(busy),
		.done(done)
	);

	// ----------------------------------------------------------------
	// Far side and read data.
	// ----------------------------------------------------------------
	// The strobe fires in the last cycle so the core sees settled data.
	assign core_req.wr_stb = done && !access_is_read;
	assign core_req.rd_stb = done && access_is_read;
	assign core_req.index = index;
	assign core_req.wdata = data_window;

	// Read data is registered; a disabled gateway hides address and data.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_req.rd) begin
			if (rial_hit(sfr_req, RIAL_OFS_KEY)) begin
				sfr_rdata <= lock_state_code; // [RQ1]
			end else if (rial_hit(sfr_req, RIAL_OFS_ADDR) && open) begin
				sfr_rdata <= {busy, auto_read_enable, 1'b0, short_strobe, index}; // [RQ10]
			end else if (rial_hit(sfr_req, RIAL_OFS_DATA) && open) begin
				sfr_rdata <= data_window;
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	AST_FIRST_KEY: assert property (@(posedge core_clk) disable iff (rst) // [RQ1]
		lock_state == RIAL_LOCKED && key_wr && !illegal_access &&
		sfr_req.wdata == RIAL_KEY_FIRST |=> lock_state_code == RIAL_CODE_WAIT2)
		else $error("first key did not reach code 1");
	AST_SECOND_KEY: assert property (@(posedge core_clk) disable iff (rst) // [RQ2]
		lock_state == RIAL_WAIT2 && key_wr && !illegal_access &&
		sfr_req.wdata == RIAL_KEY_SECOND |=> lock_state_code == RIAL_CODE_OPEN)
		else $error("second key did not unlock");
	AST_BAD_SECOND: assert property (@(posedge core_clk) disable iff (rst) // [RQ5]
		lock_state == RIAL_WAIT2 && key_wr &&
		sfr_req.wdata != RIAL_KEY_SECOND |=> lock_state_code == RIAL_CODE_DISABLED)
		else $error("wrong second key did not disable");
	AST_RELOCK: assert property (@(posedge core_clk) disable iff (rst) // [RQ6]
		open && key_wr |=> lock_state_code == RIAL_CODE_LOCKED)
		else $error("key write while open did not relock");
	AST_STAY_DISABLED: assert property (@(posedge core_clk) disable iff (rst) // [RQ3]
		lock_state == RIAL_DISABLED |=> lock_state == RIAL_DISABLED [*3])
		else $error("disabled state left before reset");
	AST_LOCKED_ACCESS: assert property (@(posedge core_clk) disable iff (rst) // [RQ16]
		lock_state == RIAL_LOCKED && (dat_wr || dat_rd) |=> lock_state == RIAL_DISABLED && !busy)
		else $error("locked data access not punished");
	AST_INDEX_STEP: assert property (@(posedge core_clk) disable iff (rst) // [RQ13]
		done && rial_is_multibyte(index) |=> index == $past(index) + 4'h1)
		else $error("multibyte index did not step");
	AST_READ_LOAD: assert property (@(posedge core_clk) disable iff (rst) // [RQ20]
		core_req.rd_stb |=> !busy && data_window == $past(core_rdata))
		else $error("read data not loaded at completion");
	AST_UNUSED_ZERO: assert property (@(posedge core_clk) disable iff (rst) // [RQ10]
		sfr_req.rd && rial_hit(sfr_req, RIAL_OFS_ADDR) |=> !sfr_rdata[RIAL_BIT_UNUSED])
		else $error("unused address bit read as one");
	AST_AUTOREAD: assert property (@(posedge core_clk) disable iff (rst) // [RQ19]
		open && dat_rd && auto_read_enable && !busy |=> busy ##5
		(short_strobe ? core_req.rd_stb : busy) ##1 (short_strobe ? !busy : core_req.rd_stb))
		else $error("auto-read did not start a read");

endmodule // rial_gateway

//--- sim/rial_core_model.sv
// ----------------------------------------------------------------
// Clock core stand-in behind the indirect access strobes.
// ----------------------------------------------------------------
module rial_core_model (
	input wire logic core_clk,
	input wire rial_pkg::rial_core_req_t core_req,
	output logic [7:0] core_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	import rial_pkg::*;

	logic [7:0] mem [16];
	logic [7:0] junk = 8'h3C;

	// Each internal byte starts at 0x40 plus its index, so reads are easy to predict.
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 8'h40 + 8'(i);
		end
	end

	// Writes land on the strobe edge; the junk pattern flips every cycle.
	always @(posedge core_clk) begin
		if (core_req.wr_stb) begin
			mem[core_req.index] <= core_req.wdata;
		end
		junk <= ~junk;
	end

	// Read data is only valid under the strobe, so it is scrambled otherwise.
	assign core_rdata = core_req.rd_stb ? mem[core_req.index] : junk;
endmodule // rial_core_model

//--- sim/tb.sv
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rial_pkg::*;

	// ----------------------------------------------------------------
	// Clock, reset and the device under test.
	// ----------------------------------------------------------------
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	rial_sfr_req_t sfr_req = '0;
	logic [7:0] sfr_rdata;
	logic [7:0] core_rdata;
	rial_core_req_t core_req;
	logic [7:0] v;
	int n_errors = 0;
	int checks = 0;
	int n;

	// The clock toggles every half period of 5 ns.
	always #5 core_clk = ~core_clk;

	rial_gateway uut (.core_clk(core_clk), .rst(rst), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .core_req(core_req), .core_rdata(core_rdata));
	rial_core_model core (.core_clk(core_clk), .core_req(core_req), .core_rdata(core_rdata));

	// ----------------------------------------------------------------
	// Bus helpers.
	// ----------------------------------------------------------------
	// One-cycle register access; a read is a request with the write bit low.
	task put(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfr_req <= {w, ~w, a, d};
		@(posedge core_clk);
		sfr_req <= '0;
	endtask

	// Read data is registered, so it is sampled one edge after the request.
	task get(input logic [7:0] a, input logic [7:0] e);
		put(1'b0, a, 8'h00);
		@(posedge core_clk);
		#1 v = sfr_rdata;
		`CHK(v, e)
	endtask

	// Counts cycles from the request to the core strobe, the request cycle being zero.
	task wait_strobe(input int exp);
		n = 1;
		#1;
		while (!(core_req.wr_stb || core_req.rd_stb) && n < 20) begin
			@(posedge core_clk);
			#1 n++;
		end
		`CHK(n, exp)
	endtask

	task do_reset();
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task t_unlock();
		get(RIAL_OFS_KEY, RIAL_CODE_LOCKED);
		put(1'b1, RIAL_OFS_KEY, RIAL_KEY_FIRST);
		get(RIAL_OFS_KEY, RIAL_CODE_WAIT2);
		put(1'b1, RIAL_OFS_KEY, RIAL_KEY_SECOND);
		get(RIAL_OFS_KEY, RIAL_CODE_OPEN);
		get(RIAL_OFS_ADDR, RIAL_RST_ADDR);
		get(RIAL_OFS_DATA, RIAL_RST_DATA);
		$display("test unlock done");
	endtask

	// Short timing, unused bit set on purpose, write to a match byte.
	task t_write();
		put(1'b1, RIAL_OFS_ADDR, 8'h3A);
		get(RIAL_OFS_ADDR, 8'h1A);
		put(1'b1, RIAL_OFS_DATA, 8'h5A);
		wait_strobe(RIAL_CYC_SHORT);
		`CHK(core_req.wr_stb, 1'b1)
		`CHK(core_req.index, 4'hA)
		`CHK(core_req.wdata, 8'h5A)
		@(posedge core_clk);
		get(RIAL_OFS_ADDR, 8'h1B);
		`CHK(core.mem[10], 8'h5A)
		get(RIAL_OFS_DATA, 8'h5A);
		$display("test write done");
	endtask

	// Normal timing read of a control byte that must not auto-increment.
	task t_read();
		put(1'b1, RIAL_OFS_ADDR, 8'h84);
		get(RIAL_OFS_ADDR, 8'h84);
		// The status read used three of the seven cycles; the old short setting must not apply.
		wait_strobe(RIAL_CYC_NORMAL - 3);
		`CHK(core_req.rd_stb, 1'b1)
		get(RIAL_OFS_ADDR, 8'h04);
		get(RIAL_OFS_DATA, 8'h44);
		$display("test read done");
	endtask

	// Short timing set with busy; each data read restarts a read, the data register only read.
	task t_auto();
		put(1'b1, RIAL_OFS_ADDR, 8'hD0);
		wait_strobe(RIAL_CYC_SHORT);
		`CHK(core_req.rd_stb, 1'b1)
		@(posedge core_clk);
		get(RIAL_OFS_ADDR, 8'h51);
		get(RIAL_OFS_DATA, 8'h40);
		repeat (10) @(posedge core_clk);
		get(RIAL_OFS_DATA, 8'h41);
		repeat (10) @(posedge core_clk);
		get(RIAL_OFS_ADDR, 8'h53);
		put(1'b1, RIAL_OFS_ADDR, 8'h00);
		get(RIAL_OFS_ADDR, 8'h00);
		$display("test auto-read done");
	endtask

	task t_relock();
		put(1'b1, RIAL_OFS_KEY, 8'h00);
		get(RIAL_OFS_KEY, RIAL_CODE_LOCKED);
		put(1'b1, RIAL_OFS_KEY, RIAL_KEY_FIRST);
		put(1'b1, RIAL_OFS_KEY, 8'h00);
		get(RIAL_OFS_KEY, RIAL_CODE_DISABLED);
		put(1'b1, RIAL_OFS_KEY, RIAL_KEY_FIRST);
		put(1'b1, RIAL_OFS_KEY, RIAL_KEY_SECOND);
		get(RIAL_OFS_KEY, RIAL_CODE_DISABLED);
		get(RIAL_OFS_DATA, 8'h00);
		$display("test relock done");
	endtask

	// A data read while locked must shut the gateway.
	task t_locked_access();
		do_reset();
		get(RIAL_OFS_KEY, RIAL_CODE_LOCKED);
		get(RIAL_OFS_DATA, 8'h00);
		get(RIAL_OFS_KEY, RIAL_CODE_DISABLED);
		$display("test locked access done");
	endtask

	// ----------------------------------------------------------------
	// Verdict, main sequence and watchdog.
	// ----------------------------------------------------------------
	task finish_test();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		do_reset();
		t_unlock();
		t_write();
		t_read();
		t_auto();
		t_relock();
		t_locked_access();
		finish_test();
	end

	// The whole run needs well under 1000 cycles, so 5000 means a hang.
	initial begin
		#50000;
		n_errors++;
		finish_test();
	end
endmodule // tb
